// file: logic/csrmc_top.sv
// Core special register bank with mode control behind an APB slave
//
// Overview of operation
// - Pointer register selects indirect access target
// - Interrupt enable set by enable, cleared by disable or interrupt taken
// - Time-out flag: set reset/sleep/clear, watchdog clears
// - Power-down flag: set reset/clear, sleep clears
// - Zero flag follows zero ALU result
// - Half carry and carry from ALU, writable
// - Status bits 6 and 5 read zero
// - Three port data registers at 05-07
// - Direction bit 0 drives, 1 floats
// - Mode bit 7 picks clock, stops main
// - Mode bit 6 picks sleep or idle
// - Crystal wake to normal waits 510 main
// - Wake to green waits 8 sub clocks
// - RC wake to normal waits 8 main
// - RC code maps 1, 8, 16, 4 MHz
// - Mode bits 5 to 3 read zero
// - Bank bit 4 picks special bank
// - Bank bits 2-0 pick general RAM bank
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "csrmc_consts.svh"
module csrmc_top
    import csrmc_pkg::*;
#(
    parameter logic [15:0] OSC_START_CYC = 16'd64,
    parameter logic [15:0] SUB_DIV = 16'd16
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [9:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // Instruction core
    input wire csrmc_instr_t i_instr,
    input wire csrmc_alu_t i_alu,
    input wire logic [7:0] i_pc_low,
    input wire logic i_wake,
    input wire logic i_osc_is_crystal,
    output logic o_pc_load,
    output logic [7:0] o_pc_data,
    output logic o_irq_enable,
    // Clock and mode control
    output logic o_cpu_run,
    output logic o_cpu_clk_main,
    output logic o_main_osc_en,
    output logic [4:0] o_rc_freq_mhz,
    output logic [2:0] o_mode,
    // Port pins
    input wire csrmc_port_t i_port_pin,
    output csrmc_port_t o_port_out,
    output csrmc_port_t o_port_oe_n
);
    logic [7:0] bank_r; // Special and general bank select
    logic [7:0] stat_r; // Core status
    logic [7:0] ptr_r; // Indirect pointer
    logic [7:0] omc_r; // Operating mode control
    csrmc_port_t data_r; // Port output latches
    csrmc_port_t dir_r; // Port direction, 1 floats
    csrmc_port_t pin_s1_r; // First sync stage
    csrmc_port_t pin_s2_r; // Second sync stage
    logic [7:0] ram [0:`CSRMC_RAM_WORDS-1]; // General purpose RAM
    logic pready_r;
    logic [31:0] prdata_r;
    csrmc_state_t state_r;
    logic tgt_main_r; // Wake target is normal mode
    logic [15:0] osc_cnt_r; // Start-up wait counter
    logic [9:0] post_cnt_r; // Post-start clock counter
    logic [9:0] post_lim_r; // Clocks to count after start-up
    logic [15:0] div_cnt_r; // Sub clock divider
    logic sub_tick_r; // One-cycle sub clock enable
    logic [4:0] rc_mhz_r;
    logic pc_load_r;
    logic [7:0] pc_data_r;
    logic [7:0] eff_a; // Resolved register address
    logic wr_fire; // Write completes this edge
    logic [7:0] wbyte;

    // Maps a general register address onto the RAM array
    function automatic logic [10:0] ram_idx(input logic [7:0] a,
                                            input logic [2:0] gb);
        if (a >= `CSRMC_GP_BANKED) begin
            ram_idx = `CSRMC_GP_COMMON_N + {1'b0, gb, a[6:0]};
        end else begin
            ram_idx = {3'b000, a} - {3'b000, `CSRMC_GP_COMMON};
        end
    endfunction : ram_idx

    // True for the port and direction ranges in special bank 0
    function automatic logic in_range(input logic [7:0] a,
                                      input logic [7:0] lo);
        in_range = (a >= lo) && (a <= lo + 8'h02);
    endfunction : in_range

    // Read value of one register; in bank 1 only specials 01-04 stay mapped
    function automatic logic [7:0] rd_val(input logic [7:0] a);
        logic [1:0] n;
        n = 2'b00;
        rd_val = 8'h00;
        if (a >= `CSRMC_GP_COMMON) begin
            rd_val = ram[ram_idx(a, bank_r[2:0])];
        end else if (a == `CSRMC_IDX_BANK) begin
            rd_val = bank_r;
        end else if (a == `CSRMC_IDX_PCL) begin
            rd_val = i_pc_low;
        end else if (a == `CSRMC_IDX_STAT) begin
            rd_val = stat_r;
        end else if (a == `CSRMC_IDX_PTR) begin
            rd_val = ptr_r;
        end else if (!bank_r[`CSRMC_BK_SPECIAL]) begin
            if (in_range(a, `CSRMC_IDX_P5)) begin
                n = 2'(a - `CSRMC_IDX_P5);
                // Inputs show the pin, outputs the latch
                rd_val = (pin_s2_r[n] & dir_r[n]) |
                         (data_r[n] & ~dir_r[n]);
            end else if (in_range(a, `CSRMC_IDX_D5)) begin
                n = 2'(a - `CSRMC_IDX_D5);
                rd_val = dir_r[n];
            end else if (a == `CSRMC_IDX_OMC) begin
                rd_val = omc_r;
            end
        end
    endfunction : rd_val

    // Index 0 redirects through the pointer
    assign eff_a = (i_paddr[9:2] == `CSRMC_IDX_IND) ? ptr_r
                                                   : i_paddr[9:2];
    assign wr_fire = i_psel & i_penable & i_pwrite & pready_r;
    assign wbyte = i_pwdata[7:0];

    // Zero-wait APB: ready raised for the first access cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= i_psel & ~i_penable & ~pready_r;
            if (i_psel & ~i_penable & ~i_pwrite) begin
                // Pointer at itself has nothing behind it
                prdata_r <= {24'h000000, (eff_a == `CSRMC_IDX_IND) ?
                             8'h00 : rd_val(eff_a)};
            end
        end
    end

    // Bank select and pointer
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            bank_r <= 8'h00;
            ptr_r <= 8'h00;
        end else if (wr_fire) begin
            if (eff_a == `CSRMC_IDX_BANK) begin
                bank_r <= wbyte & `CSRMC_BANK_MASK;
            end
            if (eff_a == `CSRMC_IDX_PTR) begin
                ptr_r <= wbyte;
            end
        end
    end

    // General RAM; no reset, contents are undefined at power-up
    always_ff @(posedge i_ref_clk) begin
        if (wr_fire && eff_a >= `CSRMC_GP_COMMON) begin
            ram[ram_idx(eff_a, bank_r[2:0])] <= wbyte;
        end
    end

    // Program counter low byte is held by the core; pass writes out
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            pc_load_r <= 1'b0;
            pc_data_r <= 8'h00;
        end else begin
            pc_load_r <= wr_fire && eff_a == `CSRMC_IDX_PCL;
            if (wr_fire && eff_a == `CSRMC_IDX_PCL) begin
                pc_data_r <= wbyte;
            end
        end
    end

    // Status flags; hardware events override a software write
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            stat_r <= `CSRMC_STAT_RST;
        end else begin
            if (wr_fire && eff_a == `CSRMC_IDX_STAT) begin
                stat_r[4:0] <= wbyte[4:0];
            end
            if (i_alu.valid) begin
                stat_r[`CSRMC_ST_Z] <= i_alu.zero;
                stat_r[`CSRMC_ST_DC] <= i_alu.half_carry;
                stat_r[`CSRMC_ST_C] <= i_alu.carry;
            end
            // Enable wins when it meets a clear
            if (i_instr.interrupts_on_instr) begin
                stat_r[`CSRMC_ST_IE] <= 1'b1;
            end else if (i_instr.interrupts_off_instr | i_instr.irq_taken) begin
                stat_r[`CSRMC_ST_IE] <= 1'b0;
            end
            if (i_instr.sleep | i_instr.watchdog_clear_instr) begin
                stat_r[`CSRMC_ST_TO] <= 1'b1;
            end else if (i_instr.wdt_timeout) begin
                stat_r[`CSRMC_ST_TO] <= 1'b0;
            end
            if (i_instr.watchdog_clear_instr) begin
                stat_r[`CSRMC_ST_PD] <= 1'b1;
            end else if (i_instr.sleep) begin
                stat_r[`CSRMC_ST_PD] <= 1'b0;
            end
        end
    end

    // Port data and direction
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            data_r <= '0;
            dir_r <= {3{`CSRMC_DIR_RST}};
        end else if (wr_fire && !bank_r[`CSRMC_BK_SPECIAL]) begin
            if (in_range(eff_a, `CSRMC_IDX_P5)) begin
                data_r[2'(eff_a - `CSRMC_IDX_P5)] <= wbyte;
            end
            if (in_range(eff_a, `CSRMC_IDX_D5)) begin
                dir_r[2'(eff_a - `CSRMC_IDX_D5)] <= wbyte;
            end
        end
    end

    // Pin synchroniser, two stages before any reader
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else begin
            pin_s1_r <= i_port_pin;
            pin_s2_r <= pin_s1_r;
        end
    end

    // Operating mode control register
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            omc_r <= `CSRMC_OMC_RST;
        end else if (wr_fire && eff_a == `CSRMC_IDX_OMC &&
                     !bank_r[`CSRMC_BK_SPECIAL]) begin
            omc_r <= wbyte & `CSRMC_OMC_MASK;
        end
    end

    // RC frequency decode, registered for the output
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            rc_mhz_r <= `CSRMC_RC_MHZ_00;
        end else begin
            unique case (omc_r[1:0])
                2'b00: rc_mhz_r <= `CSRMC_RC_MHZ_00;
                2'b01: rc_mhz_r <= `CSRMC_RC_MHZ_01;
                2'b10: rc_mhz_r <= `CSRMC_RC_MHZ_10;
                2'b11: rc_mhz_r <= `CSRMC_RC_MHZ_11;
            endcase
        end
    end

    // Sub clock enable from a divider of the reference clock
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            div_cnt_r <= 16'h0000;
            sub_tick_r <= 1'b0;
        end else begin
            sub_tick_r <= div_cnt_r == SUB_DIV - 16'h0001;
            div_cnt_r <= (div_cnt_r == SUB_DIV - 16'h0001) ? 16'h0000
                         : div_cnt_r + 16'h0001;
        end
    end

    // Mode sequencer: start-up wait, then post-start clock count
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state_r <= ST_NORMAL;
            tgt_main_r <= 1'b1;
            osc_cnt_r <= 16'h0000;
            post_cnt_r <= 10'h000;
            post_lim_r <= 10'h000;
        end else begin
            unique case (state_r)
                ST_NORMAL, ST_GREEN: begin
                    if (i_instr.sleep) begin
                        state_r <= omc_r[`CSRMC_OM_IDLE] ? ST_IDLE
                                   : ST_SLEEP;
                    end else if (state_r == ST_NORMAL &&
                                 !omc_r[`CSRMC_OM_CLK]) begin
                        state_r <= ST_GREEN;
                    end else if (state_r == ST_GREEN &&
                                 omc_r[`CSRMC_OM_CLK]) begin
                        // Main oscillator must restart first
                        state_r <= ST_OSC;
                        tgt_main_r <= 1'b1;
                        post_lim_r <= i_osc_is_crystal ?
                            `CSRMC_WAIT_XTAL_MAIN
                            : `CSRMC_WAIT_IRC_MAIN;
                        osc_cnt_r <= 16'h0000;
                    end
                end
                ST_SLEEP, ST_IDLE: begin
                    if (i_wake) begin
                        state_r <= ST_OSC;
                        tgt_main_r <= omc_r[`CSRMC_OM_CLK];
                        osc_cnt_r <= 16'h0000;
                        if (!omc_r[`CSRMC_OM_CLK]) begin
                            post_lim_r <= `CSRMC_WAIT_SUB;
                        end else if (i_osc_is_crystal) begin
                            post_lim_r <= `CSRMC_WAIT_XTAL_MAIN;
                        end else begin
                            post_lim_r <= `CSRMC_WAIT_IRC_MAIN;
                        end
                    end
                end
                ST_OSC: begin
                    osc_cnt_r <= osc_cnt_r + 16'h0001;
                    if (osc_cnt_r == OSC_START_CYC - 16'h0001) begin
                        state_r <= ST_CNT;
                        post_cnt_r <= 10'h000;
                    end
                end
                ST_CNT: begin
                    // Main clock ticks every cycle, sub on its enable
                    if (tgt_main_r || sub_tick_r) begin
                        post_cnt_r <= post_cnt_r + 10'h001;
                        if (post_cnt_r == post_lim_r - 10'h001) begin
                            state_r <= tgt_main_r ? ST_NORMAL
                                       : ST_GREEN;
                        end
                    end
                end
                default: state_r <= ST_NORMAL;
            endcase
        end
    end

    // Clock gating and oscillator enables, from flops
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_cpu_run <= 1'b0;
            o_main_osc_en <= 1'b1;
            o_cpu_clk_main <= 1'b1;
        end else begin
            o_cpu_run <= state_r == ST_NORMAL ||
                         state_r == ST_GREEN;
            o_cpu_clk_main <= omc_r[`CSRMC_OM_CLK];
            o_main_osc_en <= state_r == ST_NORMAL ||
                             ((state_r == ST_OSC || state_r == ST_CNT) &&
                              tgt_main_r);
        end
    end

    // Output registers for the rest; o_pslverr is tied low
    assign o_pready = pready_r;
    assign o_prdata = prdata_r;
    assign o_pslverr = 1'b0;
    assign o_pc_load = pc_load_r;
    assign o_pc_data = pc_data_r;
    assign o_irq_enable = stat_r[`CSRMC_ST_IE];
    assign o_rc_freq_mhz = rc_mhz_r;
    assign o_mode = state_r;
    assign o_port_out = data_r;
    assign o_port_oe_n = dir_r;

    // Cycles spent counting after start-up, for the checks
    logic [10:0] hc_r;
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || state_r != ST_CNT) begin
            hc_r <= 11'h000;
        end else begin
            hc_r <= hc_r + 11'h001;
        end
    end

    property p_ie_set;
        @(posedge i_ref_clk) disable iff (i_reset)
        i_instr.interrupts_on_instr |=> stat_r[7];
    endproperty
    a_ie_set: assert property (p_ie_set)
        else $error("enable did not set interrupt flag");
    property p_ie_clr;
        @(posedge i_ref_clk) disable iff (i_reset)
        (i_instr.interrupts_off_instr || i_instr.irq_taken) && !i_instr.interrupts_on_instr
            |=> !o_irq_enable;
    endproperty
    a_ie_clr: assert property (p_ie_clr)
        else $error("interrupt flag not cleared");
    property p_to;
        @(posedge i_ref_clk) disable iff (i_reset)
        i_instr.wdt_timeout && !i_instr.sleep && !i_instr.watchdog_clear_instr
            |=> !stat_r[4];
    endproperty
    a_to: assert property (p_to)
        else $error("time-out flag not cleared by watchdog");
    property p_pd;
        @(posedge i_ref_clk) disable iff (i_reset)
        i_instr.sleep && !i_instr.watchdog_clear_instr |=> !stat_r[3] && stat_r[4];
    endproperty
    a_pd: assert property (p_pd)
        else $error("sleep did not update power flags");
    property p_zero;
        @(posedge i_ref_clk) disable iff (i_reset)
        i_alu.valid && i_alu.zero |=> stat_r[2];
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag missed");
    property p_unimp;
        @(posedge i_ref_clk) disable iff (i_reset)
        o_pready |-> o_prdata[31:8] == 24'h0 && stat_r[6:5] == 2'b00
            && omc_r[5:3] == 3'b000;
    endproperty
    a_unimp: assert property (p_unimp)
        else $error("unimplemented bits not zero");
    property p_idle;
        @(posedge i_ref_clk) disable iff (i_reset)
        state_r == ST_NORMAL && i_instr.sleep
            |=> state_r == (omc_r[6] ? ST_IDLE : ST_SLEEP);
    endproperty
    a_idle: assert property (p_idle)
        else $error("wrong low power mode entered");
    property p_xtal;
        @(posedge i_ref_clk) disable iff (i_reset)
        $fell(state_r == ST_CNT) && tgt_main_r
            |-> $past(hc_r) == 11'd509 || post_lim_r != 10'd510;
    endproperty
    a_xtal: assert property (p_xtal)
        else $error("crystal wake did not count 510 clocks");
    property p_gate;
        @(posedge i_ref_clk) disable iff (i_reset)
        state_r == ST_OSC || state_r == ST_CNT |=> !o_cpu_run;
    endproperty
    a_gate: assert property (p_gate)
        else $error("cpu clock ran during wake wait");
    property p_rc;
        @(posedge i_ref_clk) disable iff (i_reset)
        omc_r[1:0] == 2'b10 |=> o_rc_freq_mhz == 5'd16;
    endproperty
    a_rc: assert property (p_rc)
        else $error("rc frequency decode wrong");
endmodule : csrmc_top
`default_nettype wire

// file: logic/csrmc_consts.svh
// Register indices, field positions, reset values and wait counts
`ifndef CSRMC_CONSTS_SVH
`define CSRMC_CONSTS_SVH
// Register indices (byte address on the bus is four times the index)
`define CSRMC_IDX_IND 8'h00
`define CSRMC_IDX_BANK 8'h01
`define CSRMC_IDX_PCL 8'h02
`define CSRMC_IDX_STAT 8'h03
`define CSRMC_IDX_PTR 8'h04
`define CSRMC_IDX_P5 8'h05
`define CSRMC_IDX_P7 8'h07
`define CSRMC_IDX_D5 8'h0b
`define CSRMC_IDX_D7 8'h0d
`define CSRMC_IDX_OMC 8'h0e
`define CSRMC_GP_COMMON 8'h50
`define CSRMC_GP_BANKED 8'h80
`define CSRMC_GP_COMMON_N 11'd48
`define CSRMC_RAM_WORDS 1072
// Status field positions
`define CSRMC_ST_IE 7
`define CSRMC_ST_TO 4
`define CSRMC_ST_PD 3
`define CSRMC_ST_Z 2
`define CSRMC_ST_DC 1
`define CSRMC_ST_C 0
// Mode control and bank select field positions
`define CSRMC_OM_CLK 7
`define CSRMC_OM_IDLE 6
`define CSRMC_BK_SPECIAL 4
// Writable masks and reset values
`define CSRMC_STAT_WMASK 8'h1f
`define CSRMC_OMC_MASK 8'hc3
`define CSRMC_BANK_MASK 8'h17
`define CSRMC_STAT_RST 8'h18
`define CSRMC_OMC_RST 8'h80
`define CSRMC_DIR_RST 8'hff
// Post-start wait counts
`define CSRMC_WAIT_XTAL_MAIN 10'd510
`define CSRMC_WAIT_IRC_MAIN 10'd8
`define CSRMC_WAIT_SUB 10'd8
// Internal RC frequency in MHz per code
`define CSRMC_RC_MHZ_00 5'd1
`define CSRMC_RC_MHZ_01 5'd8
`define CSRMC_RC_MHZ_10 5'd16
`define CSRMC_RC_MHZ_11 5'd4
`endif

// file: logic/csrmc_pkg.sv
// Types shared by the special register bank
`default_nettype none
package csrmc_pkg;
    // Operating mode, one three-bit code per state, not Gray along wake path
    typedef enum logic [2:0] {
        ST_NORMAL = 3'b000,
        ST_GREEN = 3'b001,
        ST_SLEEP = 3'b011,
        ST_IDLE = 3'b010,
        ST_OSC = 3'b110,
        ST_CNT = 3'b111
    } csrmc_state_t;
    // Single-cycle events from the instruction core
    typedef struct packed {
        logic interrupts_on_instr;
        logic interrupts_off_instr;
        logic irq_taken;
        logic sleep;
        logic watchdog_clear_instr;
        logic wdt_timeout;
    } csrmc_instr_t;
    // Flag results from the ALU
    typedef struct packed {
        logic valid;
        logic zero;
        logic half_carry;
        logic carry;
    } csrmc_alu_t;
    // Three 8-bit ports, index 0 is port 5
    typedef logic [2:0][7:0] csrmc_port_t;
endpackage : csrmc_pkg
`default_nettype wire

// file: bench/csrmc_pins.sv
// Pin-side partner: outside drivers on the port pins
`timescale 1ns/1ps
`default_nettype none
module csrmc_pins
    import csrmc_pkg::*;
(
    // Design side
    input wire csrmc_port_t i_out,
    input wire csrmc_port_t i_oe_n,
    // Outside driver level
    input wire csrmc_port_t i_ext,
    // Wire level back to the design
    output var csrmc_port_t o_pin
);
    // Floating bits follow the outside driver, driven bits loop back
    assign o_pin = (i_oe_n & i_ext) | (~i_oe_n & i_out);
endmodule : csrmc_pins
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the special register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module testbench
    import csrmc_pkg::*;
;
    logic clk = 0; // Clock
    logic rst = 1; // Reset
    logic psel = 0, pen = 0, pwr = 0; // APB controls
    logic [9:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr;
    csrmc_instr_t instr = '0; // Core events
    csrmc_alu_t alu = '0;
    logic wake = 0, cryst = 1;
    logic pc_load, irq_en, run, clk_main, osc_en;
    logic [7:0] pc_data;
    logic [4:0] rc_mhz;
    logic [2:0] mode;
    csrmc_port_t ext = '0, pins, pout, oe_n; // Port side
    logic [7:0] expq[$]; // Pending read data
    logic [4:0] mhz[4] = '{5'd1, 5'd8, 5'd16, 5'd4};
    int err_total = 0, checked = 0, seed = 16, n, a, b, d;
    logic [7:0] r, s, q; // Random data and the popped note
    // 250 MHz
    always #2 clk = ~clk;
    // Short start-up wait keeps the run brief
    csrmc_top #(.OSC_START_CYC(16'd4), .SUB_DIV(16'd2)) csrmc_top_inst (
        .i_ref_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .i_instr(instr), .i_alu(alu), .i_pc_low(8'h3c), .i_wake(wake),
        .i_osc_is_crystal(cryst), .o_pc_load(pc_load),
        .o_pc_data(pc_data), .o_irq_enable(irq_en), .o_cpu_run(run),
        .o_cpu_clk_main(clk_main), .o_main_osc_en(osc_en),
        .o_rc_freq_mhz(rc_mhz), .o_mode(mode), .i_port_pin(pins),
        .o_port_out(pout), .o_port_oe_n(oe_n));
    csrmc_pins csrmc_pins_inst (.i_out(pout), .i_oe_n(oe_n), .i_ext(ext),
        .o_pin(pins));
    // Each completed read is matched to the oldest note
    // Pop once per read so a mismatch cannot eat a second note
    always @(posedge clk) begin
        if (psel && pen && pready === 1'b1 && !pwr) begin
            q = expq.pop_front();
            `CHK({pslverr, prdata}, {1'b0, 24'h0, q})
        end
        if (pc_load === 1'b1)
            `CHK(pc_data, 8'ha5)
    end
    // Verdict, reached from the end and from any timeout
    task complete_run;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    // One APB transfer; a read notes its expected byte
    task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int k;
        if (!w)
            expq.push_back(d);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
            if (k > 20) begin
                err_total++;
                complete_run;
            end
        end while (pready !== 1'b1);
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask : apb
    // One-cycle core event
    task pulse(input csrmc_instr_t v);
        instr <= v;
        @(posedge clk);
        instr <= '0;
        @(posedge clk);
    endtask : pulse
    // Time the start-up wait and the post count until the target mode
    task settle(input int ecnt, input logic [2:0] tm);
        a = 0;
        b = 0;
        d = (tm == 3'b001) ? 2 : 1; // Sub tick every second cycle
        for (n = 0; n < 3000 && mode !== tm; n++) begin
            if (mode === 3'b110) a++;
            if (mode === 3'b111) b++;
            @(posedge clk);
        end
        if (mode !== tm) begin
            err_total++;
            complete_run;
        end
        `CHK(a, 4)
        `CHK((b + d - 1) / d, ecnt)
        repeat (2) @(posedge clk);
        `CHK(run, 1'b1)
    endtask : settle
    // Power down, then wake through the sequencer
    task wake_up(input logic x, input int ecnt, input logic [2:0] em,
                 input logic [2:0] tm);
        cryst <= x;
        pulse(6'b000100);
        `CHK(mode, em)
        wake <= 1;
        @(posedge clk);
        `CHK(run, 1'b0)
        wake <= 0;
        settle(ecnt, tm);
    endtask : wake_up
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        apb(0, 8'h03, 8'h18);
        apb(0, 8'h0e, 8'h80);
        apb(0, 8'h01, 8'h00);
        apb(1, 8'h03, 8'hff);
        apb(0, 8'h03, 8'h1f);
        apb(1, 8'h03, 8'h00);
        pulse(6'b100000);
        `CHK(irq_en, 1'b1)
        pulse(6'b001000);
        apb(0, 8'h03, 8'h00);
        pulse(6'b100000);
        pulse(6'b010000);
        `CHK(irq_en, 1'b0)
        alu <= 4'b1110;
        @(posedge clk);
        alu <= 4'b1001;
        @(posedge clk);
        alu <= '0;
        apb(0, 8'h03, 8'h01);
        pulse(6'b000010);
        apb(0, 8'h03, 8'h19);
        pulse(6'b000001);
        apb(0, 8'h03, 8'h09);
        apb(1, 8'h0e, 8'hff);
        apb(0, 8'h0e, 8'hc3);
        // Every RC code, settled one edge after the write
        for (n = 0; n < 4; n++) begin
            apb(1, 8'h0e, 8'h80 | n[7:0]);
            @(posedge clk);
            `CHK(rc_mhz, mhz[n])
        end
        apb(1, 8'h0e, 8'h00);
        repeat (2) @(posedge clk);
        `CHK({osc_en, clk_main}, 2'b00)
        apb(1, 8'h0e, 8'h80);
        settle(510, 3'b000);
        wake_up(1'b1, 510, 3'b011, 3'b000);
        apb(0, 8'h03, 8'h11);
        apb(1, 8'h0e, 8'hc0);
        wake_up(1'b0, 8, 3'b010, 3'b000);
        // Green, idle, wake back to green, then up to normal
        apb(1, 8'h0e, 8'h40);
        wake_up(1'b0, 8, 3'b010, 3'b001);
        `CHK({osc_en, clk_main}, 2'b00)
        apb(1, 8'h0e, 8'hc0);
        settle(8, 3'b000);
        // Indirect access and bank selection
        r = 8'($random(seed));
        apb(1, 8'h04, 8'h50);
        apb(1, 8'h00, r);
        apb(0, 8'h50, r);
        apb(1, 8'h01, 8'hff);
        apb(0, 8'h01, 8'h17);
        apb(0, 8'h05, 8'h00);
        apb(0, 8'h02, 8'h3c);
        apb(1, 8'h02, 8'ha5);
        `CHK(pc_data, 8'ha5)
        apb(1, 8'h01, 8'h01);
        apb(1, 8'h80, r);
        apb(1, 8'h01, 8'h02);
        apb(1, 8'h80, ~r);
        apb(0, 8'h80, ~r);
        apb(1, 8'h01, 8'h01);
        apb(0, 8'h80, r);
        apb(1, 8'h01, 8'h00);
        apb(1, 8'h30, 8'h5a);
        apb(0, 8'h30, 8'h00);
        // Each port: driven latch, then floating pin read back
        for (n = 0; n < 3; n++) begin
            r = 8'($random(seed));
            s = 8'($random(seed));
            apb(1, 8'h0b + n[7:0], 8'h00);
            apb(1, 8'h05 + n[7:0], r);
            `CHK(pout[n], r)
            `CHK(oe_n[n], 8'h00)
            ext[n] <= s;
            apb(0, 8'h05 + n[7:0], r);
            apb(1, 8'h0b + n[7:0], 8'hff);
            repeat (3) @(posedge clk);
            apb(0, 8'h05 + n[7:0], s);
        end
        complete_run;
    end
endmodule : testbench
`default_nettype wire
